// *** logic/afz_pkg.sv ***
// shared constants of the arc fault zone trip logic
package afz_pkg;
    localparam int NCH = 4; // sensor channels
    localparam int NZONE = 4; // protected zones
    localparam int NGRP = 8; // setting groups
    localparam int NOUT = 26; // status outputs that raise events
    localparam int MAX_SENS = 3; // arc point sensors per channel
    // millisecond time base
    localparam int CLK_NS = 10;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES = TICK_MS * 1000000 / CLK_NS;
    // apb byte offsets
    localparam logic [7:0] A_GEN = 8'h00;
    localparam logic [7:0] A_LIVE = 8'h04;
    localparam logic [7:0] A_ISTS = 8'h08;
    localparam logic [7:0] A_IMASK = 8'h0c;
    localparam logic [7:0] A_CCLR = 8'h10;
    localparam logic [7:0] A_TIME = 8'h14;
    localparam logic [7:0] A_CNT = 8'h20; // + 4 * zone
    localparam logic [7:0] A_GRP = 8'h40; // + 8 * group, zone cfg then current cfg
    // general register fields
    localparam int G_CNT = 0; // 2 bits per channel: configured sensors
    localparam int G_UNIT = 8; // 3 bits: configured remote units
    localparam int G_TYPE = 12; // 1 bit per channel: pressure and light type
    localparam logic [15:0] GEN_RST = 16'h0000;
    // current config fields
    localparam int C_PH = 0; // phase current enable per zone
    localparam int C_RES = 4; // residual current enable per zone
    localparam int C_NS = 8; // required samples above limit
    localparam logic [11:0] CCFG_RST = 12'h100;
    localparam logic [31:0] ZCFG_RST = 32'h0000_0000;
    // positions of the 26 outputs in the live vector
    localparam int O_LIGHT = 0;
    localparam int O_PRESS = 4;
    localparam int O_BI = 8;
    localparam int O_PHS = 9;
    localparam int O_PHB = 10;
    localparam int O_RSS = 11;
    localparam int O_RSB = 12;
    localparam int O_TRIP = 13;
    localparam int O_ZBLK = 17;
    localparam int O_SFLT = 21;
    localparam int O_UFLT = 25;
    // interrupt status bits
    localparam int I_TRIP = 0;
    localparam int I_ZBLK = 4;
    localparam int I_SFLT = 8;
    localparam int I_UFLT = 12;
    localparam int NIRQ = 13;
endpackage

// *** logic/afz_sync.sv ***
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module afz_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1; // metastable stage, read only by s2
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q; // filtered value
    } afz_sync_t;

    afz_sync_t st_reg, st_next;

    // shift and take the value only when two settled stages agree
    always_comb begin
        st_next = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < W; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.q;
endmodule

// *** logic/afz_top.sv ***
// arc fault zone trip logic: sensors, current condition, zones, faults, events, apb
//
// Functional notes
// - four channels, up to three sensors each
// - channel type light only or pressure
// - per-channel light output follows detected light
// - per-channel pressure output follows detected pressure
// - binary input state shown as output
// - phase and residual current start outputs
// - blocking input suppresses current, raises blocked
// - zone trips on light or pressure, plus current if enabled
// - blocked zone withholds trip, asserts blocked
// - sensor count mismatch raises channel fault
// - remote unit count mismatch raises fault
// - eight setting groups, one common selector
// - every output edge gives stamped event
// - per-zone trip and blocked counters, clearable
// - per-zone enables for each source
// - current needs required samples; phase/residual selectable
`timescale 1ns/10ps
module afz_top import afz_pkg::*; #(
    parameter int MS_DIV = MS_CYCLES // cycles per millisecond tick
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sensor card pins, asynchronous
    input wire logic [NCH-1:0] light_pin,
    input wire logic [NCH-1:0] pressure_pin,
    input wire logic arc_bi_pin,
    input wire logic [2*NCH-1:0] sens_det_pin,
    input wire logic [2:0] unit_det_pin,
    // current measurement, same clock
    input wire logic sample_valid,
    input wire logic phase_over,
    input wire logic res_over,
    // blocking matrix and group selection, same clock
    input wire logic phase_blk,
    input wire logic res_blk,
    input wire logic [NZONE-1:0] zone_blk,
    input wire logic [2:0] grp_sel,
    // status outputs
    output logic [NCH-1:0] light_out,
    output logic [NCH-1:0] pressure_out,
    output logic arc_bi_out,
    output logic phase_start,
    output logic phase_blocked,
    output logic res_start,
    output logic res_blocked,
    output logic [NZONE-1:0] zone_trip,
    output logic [NZONE-1:0] zone_blocked,
    output logic [NCH-1:0] sensor_fault,
    output logic unit_fault,
    // event buffer port
    output logic ev_valid,
    input wire logic ev_ready,
    output logic [4:0] ev_idx,
    output logic ev_on,
    output logic [31:0] ev_stamp,
    output logic irq
);
    typedef struct packed {
        logic [15:0] gen; // counts and channel types
        logic [NGRP-1:0][31:0] zcfg; // per zone: light en [3:0], pressure en [7:4]
        logic [NGRP-1:0][11:0] ccfg; // current enables and sample count
        logic [NIRQ-1:0] ists; // sticky interrupt status
        logic [NIRQ-1:0] imask; // interrupt mask
        logic [NOUT-1:0] outv; // registered status outputs
        logic [NOUT-1:0] pend; // edges awaiting an event
        logic [3:0] ph_cnt; // consecutive phase samples above limit
        logic [3:0] res_cnt; // consecutive residual samples above limit
        logic [16:0] div; // millisecond divider
        logic [31:0] ms; // millisecond time stamp
        logic [NZONE-1:0][15:0] tcnt; // trip counters
        logic [NZONE-1:0][15:0] bcnt; // blocked counters
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic ev_valid;
        logic [4:0] ev_idx;
        logic ev_on;
        logic [31:0] ev_stamp;
    } afz_state_t;

    afz_state_t s_reg, s_next;
    logic [NCH-1:0] light_s; // synchronised light
    logic [NCH-1:0] press_s; // synchronised pressure
    logic bi_s; // synchronised binary input
    logic [2*NCH-1:0] sdet_s; // synchronised sensor counts
    logic [2:0] udet_s; // synchronised unit count

    // one synchroniser per pin group; counts are slow-moving so per-bit agreement is enough
    afz_sync #(.W(2*NCH+1)) u_sync_sens (
        .pclk(pclk),
        .presetn(presetn),
        .d({arc_bi_pin, pressure_pin, light_pin}),
        .q({bi_s, press_s, light_s})
    );

    afz_sync #(.W(2*NCH+3)) u_sync_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .d({unit_det_pin, sens_det_pin}),
        .q({udet_s, sdet_s})
    );

    // combinational next state of the whole block
    always_comb begin
        logic acc; // apb access phase
        logic wr; // write takes effect this edge
        logic [31:0] rd; // read data for the answer
        logic err; // unmapped address
        logic ph_cond;
        logic res_cond;
        logic [11:0] cc;
        logic [31:0] zc;
        logic hit;
        logic need;
        logic cur_ok;
        logic meet;
        logic [NOUT-1:0] nv;
        logic [NOUT-1:0] chg;
        logic [NOUT-1:0] clr;
        logic [NIRQ-1:0] iev;
        logic found;
        logic [3:0] zi;
        logic [2:0] gi;
        acc = 1'b0;
        wr = 1'b0;
        rd = 32'h0000_0000;
        err = 1'b0;
        ph_cond = 1'b0;
        res_cond = 1'b0;
        cc = 12'h000;
        zc = 32'h0000_0000;
        hit = 1'b0;
        need = 1'b0;
        cur_ok = 1'b0;
        meet = 1'b0;
        nv = '0;
        chg = '0;
        clr = '0;
        iev = '0;
        found = 1'b0;
        zi = 4'h0;
        gi = 3'h0;
        s_next = s_reg;

        // millisecond base for the event stamps
        if (s_reg.div == 17'(MS_DIV - 1)) begin
            s_next.div = 17'h00000;
            s_next.ms = s_reg.ms + 32'h0000_0001;
        end else begin
            s_next.div = s_reg.div + 17'h00001;
        end

        // consecutive-sample qualification of both currents
        if (sample_valid) begin
            s_next.ph_cnt = phase_over ? ((s_reg.ph_cnt == 4'hf) ? 4'hf : s_reg.ph_cnt + 4'h1)
                                       : 4'h0;
            s_next.res_cnt = res_over ? ((s_reg.res_cnt == 4'hf) ? 4'hf : s_reg.res_cnt + 4'h1)
                                      : 4'h0;
        end
        cc = s_reg.ccfg[grp_sel];
        ph_cond = (s_reg.ph_cnt >= cc[C_NS+:4]) && (s_reg.ph_cnt != 4'h0);
        res_cond = (s_reg.res_cnt >= cc[C_NS+:4]) && (s_reg.res_cnt != 4'h0);

        // channel outputs; pressure only on the combined sensor type
        nv[O_LIGHT+:NCH] = light_s;
        nv[O_PRESS+:NCH] = press_s & s_reg.gen[G_TYPE+:NCH];
        nv[O_BI] = bi_s;
        nv[O_PHS] = ph_cond & ~phase_blk;
        nv[O_PHB] = ph_cond & phase_blk;
        nv[O_RSS] = res_cond & ~res_blk;
        nv[O_RSB] = res_cond & res_blk;

        // zone decisions from the active setting group
        zc = s_reg.zcfg[grp_sel];
        for (int z = 0; z < NZONE; z++) begin
            hit = |((nv[O_LIGHT+:NCH] & zc[8*z+:4]) | (nv[O_PRESS+:NCH] & zc[8*z+4+:4]));
            need = cc[C_PH+z] | cc[C_RES+z];
            cur_ok = (cc[C_PH+z] & nv[O_PHS]) | (cc[C_RES+z] & nv[O_RSS]);
            meet = hit & (~need | cur_ok);
            nv[O_TRIP+z] = meet & ~zone_blk[z];
            nv[O_ZBLK+z] = meet & zone_blk[z];
        end

        // fault checks stay level so they drop when counts agree again
        for (int c = 0; c < NCH; c++) begin
            nv[O_SFLT+c] = (sdet_s[2*c+:2] != s_reg.gen[G_CNT+2*c+:2]);
        end
        nv[O_UFLT] = (udet_s != s_reg.gen[G_UNIT+:3]);
        s_next.outv = nv;
        chg = nv ^ s_reg.outv;

        // rising edges of trips, blocks and faults raise interrupts
        iev[I_TRIP+:NZONE] = nv[O_TRIP+:NZONE] & ~s_reg.outv[O_TRIP+:NZONE];
        iev[I_ZBLK+:NZONE] = nv[O_ZBLK+:NZONE] & ~s_reg.outv[O_ZBLK+:NZONE];
        iev[I_SFLT+:NCH] = nv[O_SFLT+:NCH] & ~s_reg.outv[O_SFLT+:NCH];
        iev[I_UFLT] = nv[O_UFLT] & ~s_reg.outv[O_UFLT];

        // apb: pready comes one cycle into the access phase
        acc = psel & penable;
        wr = acc & s_reg.pready & pwrite;
        s_next.pready = acc & ~s_reg.pready;
        if (acc && !s_reg.pready) begin
            if (paddr[1:0] != 2'b00) begin
                err = 1'b1;
            end else if (paddr == A_GEN) begin
                rd = {16'h0000, s_reg.gen};
            end else if (paddr == A_LIVE) begin
                rd = {6'h00, s_reg.outv};
            end else if (paddr == A_ISTS) begin
                rd = {19'h00000, s_reg.ists};
            end else if (paddr == A_IMASK) begin
                rd = {19'h00000, s_reg.imask};
            end else if (paddr == A_CCLR) begin
                rd = 32'h0000_0000;
            end else if (paddr == A_TIME) begin
                rd = s_reg.ms;
            end else if (paddr >= A_CNT && paddr < A_CNT + 8'h10) begin
                zi = 4'(paddr[3:2]);
                rd = {s_reg.bcnt[zi[1:0]], s_reg.tcnt[zi[1:0]]};
            end else if (paddr >= A_GRP && paddr < A_GRP + 8'h40) begin
                gi = paddr[5:3];
                rd = paddr[2] ? {20'h00000, s_reg.ccfg[gi]} : s_reg.zcfg[gi];
            end else begin
                err = 1'b1;
            end
            s_next.prdata = err ? 32'h0000_0000 : rd;
            s_next.pslverr = err;
        end else if (s_reg.pready) begin
            s_next.prdata = 32'h0000_0000;
            s_next.pslverr = 1'b0;
        end

        // register writes at the completing edge; error answers store nothing
        if (wr && !s_reg.pslverr) begin
            if (paddr == A_GEN) begin
                s_next.gen = pwdata[15:0];
            end else if (paddr == A_IMASK) begin
                s_next.imask = pwdata[NIRQ-1:0];
            end else if (paddr >= A_GRP && paddr < A_GRP + 8'h40) begin
                gi = paddr[5:3];
                if (paddr[2]) begin
                    s_next.ccfg[gi] = pwdata[11:0];
                end else begin
                    s_next.zcfg[gi] = pwdata;
                end
            end
        end

        // sticky status: write one clears, a new event in the same cycle wins
        if (wr && !s_reg.pslverr && paddr == A_ISTS) begin
            s_next.ists = s_reg.ists & ~pwdata[NIRQ-1:0];
        end
        s_next.ists = s_next.ists | iev;
        s_next.irq = |(s_next.ists & s_reg.imask);

        // counters count rising edges; an edge in the clear cycle still counts
        for (int z = 0; z < NZONE; z++) begin
            if (wr && !s_reg.pslverr && paddr == A_CCLR && pwdata[z]) begin
                s_next.tcnt[z] = 16'h0000;
                s_next.bcnt[z] = 16'h0000;
            end
            if (iev[I_TRIP+z]) begin
                s_next.tcnt[z] = s_next.tcnt[z] + 16'h0001;
            end
            if (iev[I_ZBLK+z]) begin
                s_next.bcnt[z] = s_next.bcnt[z] + 16'h0001;
            end
        end

        // event port: lowest pending output first, one event per accepted cycle
        if (s_reg.ev_valid && ev_ready) begin
            s_next.ev_valid = 1'b0;
        end
        if (!s_next.ev_valid) begin
            for (int i = 0; i < NOUT; i++) begin
                if (s_reg.pend[i] && !found) begin
                    found = 1'b1;
                    clr[i] = 1'b1;
                    s_next.ev_valid = 1'b1;
                    s_next.ev_idx = 5'(i);
                    s_next.ev_on = s_reg.outv[i];
                    s_next.ev_stamp = s_reg.ms;
                end
            end
        end
        // a fresh edge on the bit being sent stays pending
        s_next.pend = (s_reg.pend & ~clr) | chg;
    end

    // single state register; zone enables come up empty so nothing trips before setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.gen <= GEN_RST;
            s_reg.zcfg <= {NGRP{ZCFG_RST}};
            s_reg.ccfg <= {NGRP{CCFG_RST}};
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign light_out = s_reg.outv[O_LIGHT+:NCH];
    assign pressure_out = s_reg.outv[O_PRESS+:NCH];
    assign arc_bi_out = s_reg.outv[O_BI];
    assign phase_start = s_reg.outv[O_PHS];
    assign phase_blocked = s_reg.outv[O_PHB];
    assign res_start = s_reg.outv[O_RSS];
    assign res_blocked = s_reg.outv[O_RSB];
    assign zone_trip = s_reg.outv[O_TRIP+:NZONE];
    assign zone_blocked = s_reg.outv[O_ZBLK+:NZONE];
    assign sensor_fault = s_reg.outv[O_SFLT+:NCH];
    assign unit_fault = s_reg.outv[O_UFLT];
    assign ev_valid = s_reg.ev_valid;
    assign ev_idx = s_reg.ev_idx;
    assign ev_on = s_reg.ev_on;
    assign ev_stamp = s_reg.ev_stamp;
    assign irq = s_reg.irq;
endmodule

// *** verification/afz_top_asserts.sv ***
// concurrent checks on the ports of the arc fault zone trip logic
`timescale 1ns/10ps
module afz_top_asserts import afz_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic arc_bi_pin,
    input wire logic [NCH-1:0] light_pin,
    input wire logic phase_blk,
    input wire logic res_blk,
    input wire logic [NZONE-1:0] zone_blk,
    input wire logic [NCH-1:0] light_out,
    input wire logic [NCH-1:0] pressure_out,
    input wire logic arc_bi_out,
    input wire logic phase_start,
    input wire logic res_start,
    input wire logic [NZONE-1:0] zone_trip,
    input wire logic [NZONE-1:0] zone_blocked,
    input wire logic ev_valid,
    input wire logic ev_ready,
    input wire logic [4:0] ev_idx,
    input wire logic ev_on,
    input wire logic [31:0] ev_stamp
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // light pins pass three sync stages, the filter register and an output register
    chk_light_follow: assert property ($rose(light_pin[0]) |-> ##[2:6] light_out[0])
        else $error("light output did not follow its pin");
    chk_bi_follow: assert property ($rose(arc_bi_pin) |-> ##[2:6] arc_bi_out)
        else $error("binary input status did not follow its pin");
    chk_phase_block: assert property (phase_blk |=> !phase_start)
        else $error("phase start shown while blocked");
    chk_res_block: assert property (res_blk |=> !res_start)
        else $error("residual start shown while blocked");
    // trip is registered on the same edge as the light output, yet either cycle is allowed
    chk_trip_light: assert property (zone_trip != 4'h0 |->
        (light_out | pressure_out | $past(light_out | pressure_out)) != 4'h0)
        else $error("zone trip without any light or pressure");
    chk_zone_block: assert property (1'b1 |=> (zone_trip & $past(zone_blk)) == 4'h0)
        else $error("zone tripped while its blocking input was set");
    chk_trip_excl: assert property ((zone_trip & zone_blocked) == 4'h0)
        else $error("zone trip and zone blocked together");
    chk_ev_hold: assert property (ev_valid && !ev_ready |=> ev_valid && $stable(ev_idx)
        && $stable(ev_on) && $stable(ev_stamp))
        else $error("pending event changed before acceptance");
    // the next pending edge may follow at once, but never as a repeat of the accepted one
    chk_ev_gap: assert property (ev_valid && ev_ready |=> !ev_valid
        || ev_idx != $past(ev_idx) || ev_on != $past(ev_on))
        else $error("accepted event presented again at once");
    chk_ev_index: assert property (ev_valid |-> ev_idx < 5'h1a)
        else $error("event index outside the output range");
    cov_trip: cover property (zone_trip[0]);
    cov_blocked: cover property (zone_blocked[0]);
    cov_event: cover property (ev_valid && ev_ready);
    cov_slverr: cover property (pready && pslverr);
endmodule

bind afz_top afz_top_asserts i_chk (.pclk(pclk), .presetn(presetn), .pready(pready),
    .pslverr(pslverr), .arc_bi_pin(arc_bi_pin), .light_pin(light_pin),
    .phase_blk(phase_blk), .res_blk(res_blk), .zone_blk(zone_blk), .light_out(light_out),
    .pressure_out(pressure_out), .arc_bi_out(arc_bi_out), .phase_start(phase_start),
    .res_start(res_start), .zone_trip(zone_trip), .zone_blocked(zone_blocked),
    .ev_valid(ev_valid), .ev_ready(ev_ready), .ev_idx(ev_idx), .ev_on(ev_on),
    .ev_stamp(ev_stamp));

// *** verification/afz_meas_model.sv ***
// model of the current sampler and the event buffer beside the arc logic
`timescale 1ns/10ps
module afz_meas_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic ev_valid,
    output logic ev_ready,
    output logic sample_valid
);
    logic [1:0] smp_cnt; // sample pacing
    logic [1:0] wait_cnt; // cycles an event has waited
    // one current sample every fourth cycle, so sample counts take real time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smp_cnt <= 2'h0;
            sample_valid <= 1'b0;
        end else begin
            smp_cnt <= smp_cnt + 2'h1;
            sample_valid <= (smp_cnt == 2'h3);
        end
    end
    // the buffer takes an event after one cycle, or three when slow, to stress holding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 2'h0;
            ev_ready <= 1'b0;
        end else if (ev_valid && !ev_ready) begin
            wait_cnt <= wait_cnt + 2'h1;
            ev_ready <= slow ? (wait_cnt == 2'h2) : 1'b1;
        end else begin
            // ready drops right after acceptance
            wait_cnt <= 2'h0;
            ev_ready <= 1'b0;
        end
    end
endmodule

// *** verification/afz_top_test.sv ***
// self-checking testbench of the arc fault zone trip logic
`timescale 1ns/10ps
module afz_top_test import afz_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, ev_stamp;
    logic [NCH-1:0] light_pin, pressure_pin, light_out, pressure_out, sensor_fault;
    logic [2*NCH-1:0] sens_det_pin;
    logic [2:0] unit_det_pin, grp_sel;
    logic arc_bi_pin, sample_valid, phase_over, res_over, phase_blk, res_blk;
    logic [NZONE-1:0] zone_blk, zone_trip, zone_blocked;
    logic arc_bi_out, phase_start, phase_blocked, res_start, res_blocked, unit_fault;
    logic ev_valid, ev_ready, ev_on, irq;
    logic [4:0] ev_idx, last_idx; // last accepted event index
    logic last_on; // last accepted event level
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    afz_top #(.MS_DIV(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .light_pin(light_pin), .pressure_pin(pressure_pin),
        .arc_bi_pin(arc_bi_pin), .sens_det_pin(sens_det_pin), .unit_det_pin(unit_det_pin),
        .sample_valid(sample_valid), .phase_over(phase_over), .res_over(res_over),
        .phase_blk(phase_blk), .res_blk(res_blk), .zone_blk(zone_blk), .grp_sel(grp_sel),
        .light_out(light_out), .pressure_out(pressure_out), .arc_bi_out(arc_bi_out),
        .phase_start(phase_start), .phase_blocked(phase_blocked), .res_start(res_start),
        .res_blocked(res_blocked), .zone_trip(zone_trip), .zone_blocked(zone_blocked),
        .sensor_fault(sensor_fault), .unit_fault(unit_fault), .ev_valid(ev_valid),
        .ev_ready(ev_ready), .ev_idx(ev_idx), .ev_on(ev_on), .ev_stamp(ev_stamp), .irq(irq));
    afz_meas_model i_far (.pclk(pclk), .presetn(presetn), .slow(slow), .ev_valid(ev_valid),
        .ev_ready(ev_ready), .sample_valid(sample_valid));
    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // remember what the buffer accepted
    always @(posedge pclk) begin
        if (ev_valid === 1'b1 && ev_ready === 1'b1) begin
            last_idx <= ev_idx;
            last_on <= ev_on;
        end
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic summarize;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer; holds the request until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check_val(r, exp);
    endtask
    // pins need several edges through the synchroniser before outputs settle
    task automatic live(input logic [31:0] exp);
        repeat (12) @(posedge pclk);
        rd_chk(A_LIVE, exp);
        // the status ports must agree with the live register bit for bit
        check_val({6'h0, unit_fault, sensor_fault, zone_blocked, zone_trip, res_blocked,
            res_start, phase_blocked, phase_start, arc_bi_out, pressure_out, light_out}, exp);
    endtask
    task automatic s_reset;
        logic [31:0] r;
        logic e;
        rd_chk(A_GEN, 32'h0);
        rd_chk(8'h4c, 32'h100);
        apb(1'b0, 8'h30, 32'h0, r, e);
        check_val({31'h0, e}, 32'h1);
        // a misaligned address is refused like an unmapped one
        apb(1'b0, 8'h05, 32'h0, r, e);
        check_val({31'h0, e}, 32'h1);
        live(32'h0);
    endtask
    task automatic s_events;
        logic [31:0] t1, t2;
        logic e;
        arc_bi_pin <= 1'b1;
        live(32'h100);
        check_val({26'h0, last_on, last_idx}, 32'h28);
        slow <= 1'b1;
        arc_bi_pin <= 1'b0;
        live(32'h0);
        check_val({26'h0, last_on, last_idx}, 32'h08);
        apb(1'b0, A_TIME, 32'h0, t1, e);
        repeat (46) @(posedge pclk);
        apb(1'b0, A_TIME, 32'h0, t2, e);
        check_val(t2 - t1, 32'h5);
    endtask
    task automatic s_faults;
        wr(A_GEN, 32'h201);
        live(32'h2200000);
        rd_chk(A_ISTS, 32'h1100);
        sens_det_pin <= 8'h01;
        unit_det_pin <= 3'h2;
        live(32'h0);
        wr(A_ISTS, 32'h1100);
        rd_chk(A_ISTS, 32'h0);
    endtask
    task automatic s_trip;
        wr(A_IMASK, 32'h1);
        wr(A_GRP, 32'h01);
        light_pin <= 4'h1;
        live(32'h2001);
        check_val({31'h0, irq}, 32'h1);
        rd_chk(A_CNT, 32'h1);
        wr(A_IMASK, 32'h0);
        repeat (2) @(posedge pclk);
        check_val({31'h0, irq}, 32'h0);
        wr(A_ISTS, 32'h1);
        rd_chk(A_ISTS, 32'h0);
        zone_blk <= 4'h1;
        live(32'h20001);
        zone_blk <= 4'h0;
        live(32'h2001);
        rd_chk(A_CNT, 32'h10002);
        wr(A_CCLR, 32'h1);
        rd_chk(A_CNT, 32'h0);
    endtask
    task automatic s_current;
        wr(8'h44, 32'h201);
        live(32'h1);
        phase_over <= 1'b1;
        live(32'h2201);
        phase_blk <= 1'b1;
        live(32'h401);
        phase_blk <= 1'b0;
        phase_over <= 1'b0;
        wr(8'h44, 32'h211);
        res_over <= 1'b1;
        live(32'h2801);
        res_blk <= 1'b1;
        live(32'h1001);
        res_blk <= 1'b0;
        res_over <= 1'b0;
        live(32'h1);
    endtask
    task automatic s_group;
        wr(8'h48, 32'h02);
        light_pin <= 4'h2;
        grp_sel <= 3'h1;
        live(32'h2002);
        grp_sel <= 3'h0;
        live(32'h2);
        pressure_pin <= 4'h4;
        live(32'h2);
        wr(A_GEN, 32'h4201);
        live(32'h42);
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, slow} = '0;
        {light_pin, pressure_pin, arc_bi_pin, sens_det_pin, unit_det_pin} = '0;
        {phase_over, res_over, phase_blk, res_blk, zone_blk, grp_sel} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_events();
        s_faults();
        s_trip();
        s_current();
        s_group();
        summarize();
    end
endmodule
